/* File: wwd_pkg.sv */
// Constants shared by the windowed timeout unit: register map, field layout,
// reset values and timing counts.
// Assumes a 125 MHz system clock that also serves as the osc_derived_clock.
//
// Functional notes
// - Active unit resets when counter steps from 0x40 to 0x3F.
// - Active unit resets when counter is reloaded above the window value.
// - Counter decrements once per 16384 osc_derived_clock cycles; 64 timeout steps.
// - Unit reset drives reset pin low about 30 us from the underflow.
// - Hardware activation option strap is sampled after reset release.
// - With halt option set, a halt request causes reset instead of halt.
// - Reset pin level is synchronised before clocked logic reads it.
// - Reset pin is driven low while low_supply_detector reports low supply.
// - Timeout and window resets only while activated; the counter always runs freely.
package wwd_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [31:0] WWD_OFF_CTRL   = 32'h0000_0000; // timeout_control_reg
    localparam logic [31:0] WWD_OFF_WINDOW = 32'h0000_0004;
    localparam logic [31:0] WWD_OFF_STATUS = 32'h0000_0008;
    localparam logic [31:0] WWD_OFF_MASK   = 32'h0000_000C;
    localparam logic [31:0] WWD_OFF_INFO   = 32'h0000_0010;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int WWD_CNT_W       = 7;
    localparam int WWD_ACT_BIT     = 7;  // timeout_activate
    localparam int WWD_TOP_BIT     = 6;  // counter_top_bit
    localparam int WWD_ST_W        = 4;
    localparam int WWD_ST_TIMEOUT  = 0;
    localparam int WWD_ST_WINDOW   = 1;
    localparam int WWD_ST_HALT     = 2;
    localparam int WWD_ST_SUPPLY   = 3;
    localparam int WWD_INFO_HWACT  = 0;
    localparam int WWD_INFO_HALTO  = 1;
    localparam int WWD_INFO_PIN    = 2;
    localparam int WWD_INFO_DRIVE  = 3;

    // ------------------------------------------------------------------
    // Reset values and compare points
    // ------------------------------------------------------------------
    localparam logic [6:0] WWD_CNT_RST    = 7'h7F;
    localparam logic [6:0] WWD_WIN_RST    = 7'h7F;
    localparam logic [3:0] WWD_MASK_RST   = 4'h0;
    localparam logic [6:0] WWD_CNT_EXPIRE = 7'h40;  // last value before top bit clears

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int WWD_CLK_PERIOD_NS = 8;
    localparam int WWD_PRESC_CYCLES  = 16384;
    localparam int WWD_PULSE_NS      = 30000;
    localparam int WWD_PULSE_CYCLES  =
        (WWD_PULSE_NS + WWD_CLK_PERIOD_NS - 1) / WWD_CLK_PERIOD_NS;
    localparam int WWD_STRAP_DELAY   = 3;   // edges after release before straps are valid

endpackage : wwd_pkg

/* File: wwd_sync.sv */
// Two-flop synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level; multi-bit coherence is not provided.
`timescale 1ns/1ps
module wwd_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_ff;

    // A zero-width group has nothing to carry
    if (W < 1) begin : g_bad_width
        $error("W must be at least 1");
    end

    // ------------------------------------------------------------------
    // First stage feeds only the second stage
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_ff <= '0;
            q       <= '0;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end

endmodule : wwd_sync

/* File: wwd_top.sv */
// Windowed timeout unit with AHB-Lite register slave and open-drain reset pin.
// Assumes zero-wait single word transfers; straps and the reset pin are
// asynchronous pins, halt_req comes from core logic on clk.
`timescale 1ns/1ps
module wwd_top
    import wwd_pkg::*;
#(
    parameter int PRESC_CYCLES = WWD_PRESC_CYCLES,
    parameter int PULSE_CYCLES = WWD_PULSE_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        opt_hw_activate,
    input  wire logic        opt_halt_reset,
    input  wire logic        halt_req,
    input  wire logic        supply_low,
    input  wire logic        rst_pin_i,
    output logic             rst_pin_o,
    output logic             rst_pin_oe,
    output logic             halt_enter,
    output logic             irq
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (PRESC_CYCLES < 2 || PRESC_CYCLES > 65536) begin : g_bad_presc
        $error("PRESC_CYCLES out of range");
    end
    if (PULSE_CYCLES < 1 || PULSE_CYCLES > 65535) begin : g_bad_pulse
        $error("PULSE_CYCLES out of range");
    end

    localparam logic [15:0] PRESC_LAST = 16'(PRESC_CYCLES - 1);
    localparam logic [15:0] PULSE_LOAD = 16'(PULSE_CYCLES);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [6:0]          cnt_ff;
    logic [6:0]          nxt_cnt;
    logic [15:0]         presc_ff;
    logic [15:0]         nxt_presc;
    logic                act_ff;
    logic                nxt_act;
    logic [6:0]          window_ff;
    logic [WWD_ST_W-1:0] status_ff;
    logic [WWD_ST_W-1:0] nxt_status;
    logic [WWD_ST_W-1:0] mask_ff;
    logic [15:0]         pulse_ff;
    logic [15:0]         nxt_pulse;
    logic                opt_hwact_ff;
    logic                opt_halt_ff;
    logic [1:0]          strap_cnt_ff;
    logic                supply_prev_ff;
    logic                wr_pend_ff;
    logic [31:0]         wr_addr_ff;
    logic [31:0]         hrdata_ff;
    logic                rst_pin_oe_ff;
    logic                halt_enter_ff;
    logic                irq_ff;

    logic [3:0]          sync_q;
    logic                hwact_s;
    logic                halto_s;
    logic                supply_s;
    logic                pin_s;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    wwd_sync #(
        .W (4)
    ) u_sync (
        .clk (clk),
        .rst (rst),
        .d   ({rst_pin_i, supply_low, opt_halt_reset, opt_hw_activate}),
        .q   (sync_q)
    );

    assign hwact_s  = sync_q[0];
    assign halto_s  = sync_q[1];
    assign supply_s = sync_q[2];
    assign pin_s    = sync_q[3];

    // ------------------------------------------------------------------
    // Bus address phase decode
    // ------------------------------------------------------------------
    logic        addr_ok;
    logic        wr_ctrl;
    logic        wr_window;
    logic        wr_status;
    logic        wr_mask;
    logic [6:0]  wr_cnt;

    assign addr_ok   = hsel & htrans[1] & hready;
    assign wr_ctrl   = wr_pend_ff & (wr_addr_ff == WWD_OFF_CTRL);
    assign wr_window = wr_pend_ff & (wr_addr_ff == WWD_OFF_WINDOW);
    assign wr_status = wr_pend_ff & (wr_addr_ff == WWD_OFF_STATUS);
    assign wr_mask   = wr_pend_ff & (wr_addr_ff == WWD_OFF_MASK);
    assign wr_cnt    = hwdata[WWD_CNT_W-1:0];

    // Writes land in the data phase, when hwdata is valid
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 32'h0000_0000;
        end else begin
            wr_pend_ff <= addr_ok & hwrite;
            wr_addr_ff <= {haddr[31:2], 2'b00};
        end
    end

    // ------------------------------------------------------------------
    // Straps: captured once the synchroniser holds valid pin levels
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            strap_cnt_ff <= 2'h0;
            opt_hwact_ff <= 1'b0;
            opt_halt_ff  <= 1'b0;
        end else if (strap_cnt_ff != 2'(WWD_STRAP_DELAY)) begin
            strap_cnt_ff <= strap_cnt_ff + 2'h1;
            opt_hwact_ff <= hwact_s;
            opt_halt_ff  <= halto_s;
        end
    end

    // ------------------------------------------------------------------
    // Prescaler and free-running downcounter
    // ------------------------------------------------------------------
    logic tick;

    assign tick = (presc_ff == PRESC_LAST);

    always_comb begin
        nxt_presc = tick ? 16'h0000 : presc_ff + 16'h0001;
        nxt_cnt   = tick ? cnt_ff - 7'h01 : cnt_ff;
        if (wr_ctrl) begin
            nxt_presc = 16'h0000;
            nxt_cnt   = wr_cnt;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            presc_ff <= 16'h0000;
            cnt_ff   <= WWD_CNT_RST;
        end else begin
            presc_ff <= nxt_presc;
            cnt_ff   <= nxt_cnt;
        end
    end

    // ------------------------------------------------------------------
    // Activation: set-only, cleared by reset alone
    // ------------------------------------------------------------------
    always_comb begin
        nxt_act = act_ff;
        if (wr_ctrl && hwdata[WWD_ACT_BIT]) begin
            nxt_act = 1'b1;
        end
        if (strap_cnt_ff == 2'(WWD_STRAP_DELAY - 1) && hwact_s) begin
            nxt_act = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            act_ff <= 1'b0;
        end else begin
            act_ff <= nxt_act;
        end
    end

    // ------------------------------------------------------------------
    // Reset causes
    // ------------------------------------------------------------------
    logic ev_timeout;
    logic ev_window;
    logic ev_halt;
    logic ev_supply;
    logic trig;

    // Expiry by decrement, or a write that leaves the top bit clear
    assign ev_timeout = (act_ff & tick & ~wr_ctrl & (cnt_ff == WWD_CNT_EXPIRE))
                      | (nxt_act & wr_ctrl & ~wr_cnt[WWD_TOP_BIT]);
    // Window check sees the counter as it stood before the write
    assign ev_window  = act_ff & wr_ctrl & (cnt_ff > window_ff);
    assign ev_halt    = halt_req & opt_halt_ff;
    assign ev_supply  = supply_s & ~supply_prev_ff;
    assign trig       = ev_timeout | ev_window | ev_halt;

    // ------------------------------------------------------------------
    // Reset pulse stretcher and open-drain pin
    // ------------------------------------------------------------------
    always_comb begin
        nxt_pulse = (pulse_ff != 16'h0000) ? pulse_ff - 16'h0001 : 16'h0000;
        if (trig) begin
            nxt_pulse = PULSE_LOAD;
        end
    end

    // Supply-low drives the pin directly so it tracks the detector level
    always_ff @(posedge clk) begin
        if (rst) begin
            pulse_ff       <= 16'h0000;
            rst_pin_oe_ff  <= 1'b0;
            supply_prev_ff <= 1'b0;
        end else begin
            pulse_ff       <= nxt_pulse;
            rst_pin_oe_ff  <= (nxt_pulse != 16'h0000) | supply_s;
            supply_prev_ff <= supply_s;
        end
    end

    // ------------------------------------------------------------------
    // Halt entry when no reset is taken instead
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            halt_enter_ff <= 1'b0;
        end else begin
            halt_enter_ff <= halt_req & ~opt_halt_ff;
        end
    end

    // ------------------------------------------------------------------
    // Window and mask registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            window_ff <= WWD_WIN_RST;
        end else if (wr_window) begin
            window_ff <= wr_cnt;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mask_ff <= WWD_MASK_RST;
        end else if (wr_mask) begin
            mask_ff <= hwdata[WWD_ST_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Sticky status, write one to clear; a new event beats the clear
    // ------------------------------------------------------------------
    logic [WWD_ST_W-1:0] st_set;
    logic [WWD_ST_W-1:0] st_clr;

    always_comb begin
        st_set                 = '0;
        st_set[WWD_ST_TIMEOUT] = ev_timeout;
        st_set[WWD_ST_WINDOW]  = ev_window;
        st_set[WWD_ST_HALT]    = ev_halt;
        st_set[WWD_ST_SUPPLY]  = ev_supply;
        st_clr                 = wr_status ? hwdata[WWD_ST_W-1:0] : '0;
        nxt_status             = (status_ff & ~st_clr) | st_set;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            status_ff <= '0;
            irq_ff    <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            irq_ff    <= |(nxt_status & mask_ff);
        end
    end

    // ------------------------------------------------------------------
    // Read data, sampled in the address phase
    // ------------------------------------------------------------------
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;  // Unmapped offsets read as zero
        case ({haddr[31:2], 2'b00})
            WWD_OFF_CTRL: begin
                rd_mux[WWD_CNT_W-1:0] = cnt_ff;
                rd_mux[WWD_ACT_BIT]   = act_ff;
            end
            WWD_OFF_WINDOW: begin
                rd_mux[WWD_CNT_W-1:0] = window_ff;
            end
            WWD_OFF_STATUS: begin
                rd_mux[WWD_ST_W-1:0] = status_ff;
            end
            WWD_OFF_MASK: begin
                rd_mux[WWD_ST_W-1:0] = mask_ff;
            end
            WWD_OFF_INFO: begin
                rd_mux[WWD_INFO_HWACT] = opt_hwact_ff;
                rd_mux[WWD_INFO_HALTO] = opt_halt_ff;
                rd_mux[WWD_INFO_PIN]   = pin_s;
                rd_mux[WWD_INFO_DRIVE] = rst_pin_oe_ff;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata_ff <= rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all from flops; bus never stalls and never errors
    // ------------------------------------------------------------------
    logic hreadyout_ff;
    logic hresp_ff;
    logic rst_pin_o_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            hreadyout_ff <= 1'b1;
            hresp_ff     <= 1'b0;
            rst_pin_o_ff <= 1'b0;  // Open drain: only ever pulls low
        end else begin
            hreadyout_ff <= 1'b1;
            hresp_ff     <= 1'b0;
            rst_pin_o_ff <= 1'b0;
        end
    end

    assign hrdata     = hrdata_ff;
    assign hreadyout  = hreadyout_ff;
    assign hresp      = hresp_ff;
    assign rst_pin_o  = rst_pin_o_ff;
    assign rst_pin_oe = rst_pin_oe_ff;
    assign halt_enter = halt_enter_ff;
    assign irq        = irq_ff;

    // hsize is accepted for any value; only word transfers are defined
    logic unused_ok;
    assign unused_ok = ^hsize;

endmodule : wwd_top

/* File: wwd_top_chk.sv */
// Port checker for the windowed timeout unit: reset pin, halt path.
// Assumes straps only change while rst is high; bound to wwd_top below.
`timescale 1ns/1ps
module wwd_top_chk
    import wwd_pkg::*;
#(
    parameter int PULSE_CYCLES = WWD_PULSE_CYCLES
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic        opt_hw_activate,
    input wire logic        opt_halt_reset,
    input wire logic        halt_req,
    input wire logic        supply_low,
    input wire logic        rst_pin_o,
    input wire logic        rst_pin_oe,
    input wire logic        halt_enter
);
    // ------------------------------------------------------------------
    // Helper state
    // ------------------------------------------------------------------
    logic [2:0]  since_ff;
    logic [15:0] hi_ff;
    logic        act_ff;
    logic        wr_ctrl_ff;
    wire settled   = since_ff == 3'h7;
    wire ctrl_addr = hsel && htrans[1] && hready && hwrite && haddr[31:2] == 30'h0;

    // Straps need a few edges after release before they count
    always_ff @(posedge clk) begin
        if (rst) since_ff <= 3'h0;
        else if (!settled) since_ff <= since_ff + 3'h1;
    end
    // Shadow of the activation bit; only ever set, like the real one
    always_ff @(posedge clk) begin
        if (rst) act_ff <= 1'b0;
        else if ((since_ff >= 3'h2 && opt_hw_activate) || (wr_ctrl_ff && hwdata[WWD_ACT_BIT]))
            act_ff <= 1'b1;
    end
    // Data phase marker of a control write
    always_ff @(posedge clk) begin
        wr_ctrl_ff <= !rst && ctrl_addr;
    end
    // Length of the current low drive on the pin
    always_ff @(posedge clk) begin
        if (rst || !rst_pin_oe) hi_ff <= 16'h0;
        else hi_ff <= hi_ff + 16'h1;
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence expire_wr_s;
        ctrl_addr ##1 (!hwdata[WWD_TOP_BIT] && (act_ff || hwdata[WWD_ACT_BIT]));
    endsequence
    sequence idle_wr_s;
        ctrl_addr ##1 (!hwdata[WWD_TOP_BIT] && !act_ff && !hwdata[WWD_ACT_BIT]);
    endsequence

    pulse_width_a: assert property ($fell(rst_pin_oe) |-> hi_ff >= PULSE_CYCLES)
        else $error("reset pin pulse too short");
    drive_low_a: assert property (rst_pin_oe |-> !rst_pin_o)
        else $error("reset pin driven high");
    supply_drive_a: assert property (supply_low [*3] |=> rst_pin_oe)
        else $error("low supply not driven on pin");
    expire_now_a: assert property (expire_wr_s |=> rst_pin_oe)
        else $error("expired counter write gave no reset");
    idle_quiet_a: assert property (idle_wr_s |=> !$rose(rst_pin_oe))
        else $error("reset while not activated");
    halt_reset_a: assert property (settled && halt_req && opt_halt_reset |=> rst_pin_oe && !halt_enter)
        else $error("halt did not become reset");
    halt_pass_a: assert property (settled && halt_req && !opt_halt_reset |=> halt_enter ##1 !halt_enter)
        else $error("halt pulse missing");
    halt_only_a: assert property (halt_enter |-> $past(halt_req) && !opt_halt_reset)
        else $error("halt pulse without cause");
endmodule : wwd_top_chk

bind wwd_top wwd_top_chk #(.PULSE_CYCLES(PULSE_CYCLES)) wwd_top_chk_inst (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hwdata(hwdata), .opt_hw_activate(opt_hw_activate),
    .opt_halt_reset(opt_halt_reset), .halt_req(halt_req), .supply_low(supply_low),
    .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe), .halt_enter(halt_enter)
);

/* File: tb_wwd_top.sv */
// Self-checking bench for the windowed timeout unit over its register bus.
// Assumes shortened prescaler and pulse counts; the reset pin has a pull-up.
`timescale 1ns/1ps
module tb_wwd_top
    import wwd_pkg::*;
;
    localparam int PRESC = 16;
    localparam int PULSE = 8;
    localparam int LIMIT = 20000;
    logic        clk, rst, hwrite, opt_hw, opt_hr, halt_req, supply_low, ext_low;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic        hreadyout, hresp, rst_pin_o, rst_pin_oe, halt_enter, irq;
    int          n_mismatch, comparisons, cyc, n, w;
    // Pull-up on the pin; an outside party may also hold it low
    wire rst_pin_i = rst_pin_oe ? rst_pin_o : !ext_low;

    wwd_top #(.PRESC_CYCLES(PRESC), .PULSE_CYCLES(PULSE)) wwd_top_inst (
        .clk(clk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .opt_hw_activate(opt_hw), .opt_halt_reset(opt_hr), .halt_req(halt_req),
        .supply_low(supply_low), .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o),
        .rst_pin_oe(rst_pin_oe), .halt_enter(halt_enter), .irq(irq));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic report_and_stop();
        $display("Counts: %0d mismatches, %0d comparisons", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One single transfer; read data is taken at the data phase edge
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        q = hrdata;
    endtask : bus
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(q, exp);
        check({31'h0, hresp}, 32'h0);
    endtask : rd_chk
    task automatic wait_oe();
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rst_pin_oe !== 1'b1 && n < 100);
    endtask : wait_oe
    // Counts the pulse and checks its length against the set count
    task automatic pulse();
        w = 0;
        while (rst_pin_oe === 1'b1 && w < 100) begin
            w++;
            @(posedge clk);
        end
        check({31'h0, w >= PULSE && w <= PULSE + 1}, 32'h1);
    endtask : pulse
    task automatic quiet(input int c);
        logic hit;
        hit = 1'b0;
        repeat (c) begin
            @(posedge clk);
            if (rst_pin_oe !== 1'b0) hit = 1'b1;
        end
        check({31'h0, hit}, 32'h0);
    endtask : quiet
    task automatic do_reset(input logic hw, input logic hr);
        @(posedge clk);
        rst    <= 1'b1;
        opt_hw <= hw;
        opt_hr <= hr;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
    endtask : do_reset
    task automatic halt();
        @(posedge clk);
        halt_req <= 1'b1;
        @(posedge clk);
        halt_req <= 1'b0;
    endtask : halt

    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {rst, hwrite, opt_hw, opt_hr, halt_req, supply_low, ext_low} = 7'h40;
        htrans = 2'b00;
        haddr  = 32'h0;
        hwdata = 32'h0;
        do_reset(1'b0, 1'b0);
        rd_chk(WWD_OFF_CTRL, 32'h7F);
        rd_chk(WWD_OFF_WINDOW, 32'h7F);
        rd_chk(WWD_OFF_STATUS, 32'h0);
        rd_chk(WWD_OFF_INFO, 32'h4);
        wr(32'h0000_0020, 32'hFFFF_FFFF);
        rd_chk(32'h0000_0020, 32'h0);
        @(posedge clk);
        ext_low <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(WWD_OFF_INFO, 32'h0);
        ext_low <= 1'b0;
        // Not activated: expired write and free running decrements stay silent
        wr(WWD_OFF_CTRL, 32'h3F);
        quiet(4);
        wr(WWD_OFF_CTRL, 32'h41);
        quiet(40);
        rd_chk(WWD_OFF_CTRL, 32'h3F);
        // Activated timeout after two prescaler periods
        wr(WWD_OFF_CTRL, 32'hC1);
        wait_oe();
        check({31'h0, n >= 2 * PRESC - 1 && n <= 2 * PRESC + 3}, 32'h1);
        pulse();
        rd_chk(WWD_OFF_STATUS, 32'h1);
        wr(WWD_OFF_MASK, 32'hF);
        repeat (3) @(posedge clk);
        check({31'h0, irq}, 32'h1);
        wr(WWD_OFF_STATUS, 32'h1);
        repeat (3) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        wr(WWD_OFF_CTRL, 32'h7F);
        rd_chk(WWD_OFF_CTRL, 32'hFF);
        // Refresh above the window, then on its edge
        wr(WWD_OFF_WINDOW, 32'h50);
        wr(WWD_OFF_CTRL, 32'h51);
        wait_oe();
        check({31'h0, n <= 2}, 32'h1);
        pulse();
        rd_chk(WWD_OFF_STATUS, 32'h2);
        wr(WWD_OFF_STATUS, 32'h2);
        repeat (6) @(posedge clk);
        wr(WWD_OFF_CTRL, 32'h60);
        quiet(8);
        rd_chk(WWD_OFF_CTRL, 32'hE0);
        wr(WWD_OFF_WINDOW, 32'h7F);
        wr(WWD_OFF_CTRL, 32'h3F);
        wait_oe();
        check({31'h0, n <= 2}, 32'h1);
        pulse();
        rd_chk(WWD_OFF_STATUS, 32'h1);
        wr(WWD_OFF_STATUS, 32'hF);
        // Low supply holds the pin down
        @(posedge clk);
        supply_low <= 1'b1;
        wait_oe();
        check({31'h0, n <= 5}, 32'h1);
        repeat (20) @(posedge clk);
        check({31'h0, rst_pin_oe}, 32'h1);
        supply_low <= 1'b0;
        repeat (PULSE + 6) @(posedge clk);
        check({31'h0, rst_pin_oe}, 32'h0);
        rd_chk(WWD_OFF_STATUS, 32'h8);
        // Straps: hardware activation and halt as reset
        do_reset(1'b1, 1'b1);
        rd_chk(WWD_OFF_INFO, 32'h7);
        rd_chk(WWD_OFF_CTRL, 32'hFF);
        halt();
        wait_oe();
        check({31'h0, n <= 2}, 32'h1);
        pulse();
        rd_chk(WWD_OFF_STATUS, 32'h4);
        wr(WWD_OFF_CTRL, 32'h41);
        wait_oe();
        check({31'h0, n >= 2 * PRESC - 1 && n <= 2 * PRESC + 3}, 32'h1);
        pulse();
        do_reset(1'b0, 1'b0);
        halt();
        @(posedge clk);
        check({30'h0, halt_enter, rst_pin_oe}, 32'h2);
        rd_chk(WWD_OFF_CTRL, 32'h7F);
        report_and_stop();
    end
endmodule : tb_wwd_top
